// ==== design/scc_pkg.sv ====
package scc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int BACKUP_TIME_US = 50000;
	localparam int BACKUP_CYC = BACKUP_TIME_US * CLK_MHZ;
	localparam int SETTLE_TIME_US = 20000;
	localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
	localparam int ST_LIMIT_LSB = 350;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int LEVEL_W = 12;
	localparam int OFF_W = 14;
	localparam int N_OUT = 5;
	localparam int CNT_W = 24;

	// ----------------------------------------
	// Register byte addresses (low byte, even)
	// ----------------------------------------
	localparam logic [6:0] ADDR_AUX_LEVEL = 7'h30;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_LINE = 7'h36;
	localparam logic [6:0] ADDR_STATUS = 7'h3C;
	localparam logic [6:0] ADDR_CMD = 7'h3E;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MISC_ST_FORCE = 8;
	localparam int MISC_POST = 10;
	localparam logic [15:0] MISC_MASK = 16'h0507;
	localparam int LINE_DIR_LSB = 0;
	localparam int LINE_DAT_LSB = 8;
	localparam int STAT_FLASH = 2;
	localparam int STAT_ST_FAIL = 5;
	localparam int CMD_NULL = 0;
	localparam int CMD_RESTORE = 1;
	localparam int CMD_LATCH = 2;
	localparam int CMD_BACKUP = 3;
	localparam int CMD_CLR = 4;
	localparam int CMD_RESET = 7;
	localparam int SENS_X_ACCEL = 0;
	localparam int SENS_Y_ACCEL = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_MISC = 16'h0000;
	localparam logic [1:0] RST_LINE = 2'h0;
	localparam logic [11:0] RST_LEVEL = 12'h000;
	localparam logic [13:0] RST_OFFSET = 14'h0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCC_IDLE = 3'b000,
		SCC_POST_OFF = 3'b001,
		SCC_POST_ON = 3'b010,
		SCC_BACKUP = 3'b011,
		SCC_RELOAD = 3'b100
	} scc_seq_t;

	typedef struct packed {
		logic sclk_q;
		logic [4:0] bit_cnt;
		logic [15:0] sh_rx;
		logic [15:0] sh_tx;
		logic miso;
		logic done;
		logic [15:0] rx;
	} scc_spi_t;

	typedef struct packed {
		logic [15:0] misc;
		logic [1:0] dir;
		logic [1:0] dat;
		logic [11:0] level;
		logic [11:0] latch;
		logic [N_OUT-1:0][OFF_W-1:0] offs;
		logic [15:0] nv_misc;
		logic [1:0] nv_dir;
		logic [1:0] nv_dat;
		logic [N_OUT-1:0][OFF_W-1:0] nv_offs;
		logic st_fail;
		logic fl_err;
		logic null_pend;
	} scc_regs_t;

	typedef struct packed {
		scc_seq_t seq;
		logic [CNT_W-1:0] cnt;
		scc_regs_t r;
		logic [OFF_W-1:0] x0;
		logic [OFF_W-1:0] y0;
		logic post_force;
		logic st_force;
		logic busy;
		logic restart;
		logic [15:0] tx;
	} scc_core_t;

endpackage : scc_pkg

// ==== design/scc_spi_frame.sv ====
`timescale 1ns/10ps
`default_nettype none

// SPI mode 3 frame engine, 16 bits, sclk oversampled by ref_clk
module scc_spi_frame (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	// Frame side
	input wire logic [15:0] tx_word,
	output logic frame_done,
	output logic [15:0] rx_word
);

	scc_pkg::scc_spi_t s_ff;
	scc_pkg::scc_spi_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.sclk_q = sclk;
		nxt_s.done = 1'b0;
		if (cs_n) begin
			// Reply word is loaded while deselected so its MSB is ready at select
			nxt_s.bit_cnt = 5'h00;
			nxt_s.miso = tx_word[15];
			nxt_s.sh_tx = tx_word;
		end else if (sclk && !s_ff.sclk_q) begin
			nxt_s.sh_rx = {s_ff.sh_rx[14:0], mosi};
			nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
			if (s_ff.bit_cnt == 5'(scc_pkg::FRAME_BITS - 1)) begin
				nxt_s.done = 1'b1;
				nxt_s.rx = {s_ff.sh_rx[14:0], mosi};
				nxt_s.bit_cnt = 5'h00;
			end
		end else if (!sclk && s_ff.sclk_q) begin
			nxt_s.miso = s_ff.sh_tx[15];
			nxt_s.sh_tx = {s_ff.sh_tx[14:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '{sclk_q: 1'b1, bit_cnt: 5'h00, sh_rx: 16'h0000, sh_tx: 16'h0000,
				miso: 1'b0, done: 1'b0, rx: 16'h0000};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign miso = s_ff.miso;
	assign frame_done = s_ff.done;
	assign rx_word = s_ff.rx;

endmodule : scc_spi_frame

`default_nettype wire

// ==== design/scc_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

module scc_regs #(
	parameter int BACKUP_CYCLES = scc_pkg::BACKUP_CYC,
	parameter int SETTLE_CYCLES = scc_pkg::SETTLE_CYC,
	parameter int ST_LIMIT = scc_pkg::ST_LIMIT_LSB,
	parameter logic [15:0] NV_MISC_INIT = scc_pkg::RST_MISC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial port
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	// Digital lines
	input wire logic [1:0] line_in,
	output logic [1:0] line_out,
	output logic [1:0] line_oe,
	// Sensor side
	input wire logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] sensor_out,
	input wire logic flash_ok,
	output logic st_force,
	output logic [scc_pkg::LEVEL_W-1:0] level_latch,
	output logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] offsets,
	// Sequencer
	output logic busy,
	output logic core_restart
);

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	scc_pkg::scc_core_t s_ff;
	scc_pkg::scc_core_t nxt_s;
	logic frame_done;
	logic [15:0] rx_word;

	scc_spi_frame u_frame (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.tx_word(s_ff.tx),
		.frame_done(frame_done),
		.rx_word(rx_word)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic wr;
		logic [6:0] addr;
		logic [7:0] wdat;
		logic [15:0] rd;
		logic [15:0] status;
		logic [14:0] dx;
		logic [14:0] dy;
		logic [14:0] ax;
		logic [14:0] ay;
		logic [7:0] cmd;
		logic fl_fail_ev;
		logic st_fail_ev;
		wr = frame_done & rx_word[15];
		addr = rx_word[14:8];
		wdat = rx_word[7:0];
		rd = 16'h0000;
		dx = 15'h0000;
		dy = 15'h0000;
		ax = 15'h0000;
		ay = 15'h0000;
		cmd = 8'h00;
		fl_fail_ev = 1'b0;
		st_fail_ev = 1'b0;
		nxt_s = s_ff;
		nxt_s.restart = 1'b0;
		status = 16'h0000;
		status[scc_pkg::STAT_ST_FAIL] = s_ff.r.st_fail;
		status[scc_pkg::STAT_FLASH] = s_ff.r.fl_err;

		// ------------------------------------
		// Register writes, one byte per frame
		// ------------------------------------
		if (wr) begin
			case (addr)
				scc_pkg::ADDR_MISC: nxt_s.r.misc[7:0] = wdat & scc_pkg::MISC_MASK[7:0];
				7'(scc_pkg::ADDR_MISC + 7'h01): nxt_s.r.misc[15:8] = wdat & scc_pkg::MISC_MASK[15:8];
				scc_pkg::ADDR_LINE: nxt_s.r.dir = wdat[1:0];
				7'(scc_pkg::ADDR_LINE + 7'h01): nxt_s.r.dat = wdat[1:0];
				// Held apart from the latch so byte writes leave the output steady
				scc_pkg::ADDR_AUX_LEVEL: nxt_s.r.level[7:0] = wdat;
				7'(scc_pkg::ADDR_AUX_LEVEL + 7'h01): nxt_s.r.level[11:8] = wdat[3:0];
				scc_pkg::ADDR_CMD: cmd = wdat;
				default: cmd = 8'h00;
			endcase
		end

		// ------------------------------------
		// Read reply for the next frame
		// ------------------------------------
		if (frame_done && !rx_word[15]) begin
			case ({addr[6:1], 1'b0})
				scc_pkg::ADDR_MISC: rd = s_ff.r.misc;
				scc_pkg::ADDR_LINE: begin
					rd[1:0] = s_ff.r.dir;
					rd[9:8] = line_in;
				end
				scc_pkg::ADDR_AUX_LEVEL: rd = {4'h0, s_ff.r.level};
				scc_pkg::ADDR_STATUS: begin
					rd = status;
					nxt_s.r.fl_err = 1'b0;
				end
				scc_pkg::ADDR_CMD: rd = 16'h0000;
				default: rd = 16'h0000;
			endcase
			nxt_s.tx = rd;
		end

		// ------------------------------------
		// Sequencer
		// ------------------------------------
		case (s_ff.seq)
			scc_pkg::SCC_IDLE: begin
				// Commands arriving mid-operation are dropped; host must wait
				if (cmd[scc_pkg::CMD_RESET]) begin
					nxt_s.seq = scc_pkg::SCC_RELOAD;
					nxt_s.restart = 1'b1;
					nxt_s.busy = 1'b1;
				end else begin
					if (cmd[scc_pkg::CMD_CLR]) begin
						nxt_s.r.st_fail = 1'b0;
						nxt_s.r.fl_err = 1'b0;
					end
					if (cmd[scc_pkg::CMD_LATCH]) begin
						nxt_s.r.latch = s_ff.r.level;
					end
					if (cmd[scc_pkg::CMD_RESTORE]) begin
						nxt_s.r.offs = '0;
					end
					if (cmd[scc_pkg::CMD_NULL]) begin
						for (int i = 0; i < scc_pkg::N_OUT; i++) begin
							nxt_s.r.offs[i] = 14'(-sensor_out[i]);
						end
					end
					// Error flag locks out flash until it has been read or cleared by command
					if ((cmd[scc_pkg::CMD_BACKUP] || cmd[scc_pkg::CMD_NULL]) && !s_ff.r.fl_err) begin
						nxt_s.seq = scc_pkg::SCC_BACKUP;
						nxt_s.cnt = '0;
						nxt_s.busy = 1'b1;
					end
				end
			end
			scc_pkg::SCC_RELOAD: begin
				nxt_s.r.misc = s_ff.r.nv_misc;
				nxt_s.r.dir = s_ff.r.nv_dir;
				nxt_s.r.dat = s_ff.r.nv_dat;
				nxt_s.r.offs = s_ff.r.nv_offs;
				nxt_s.r.level = scc_pkg::RST_LEVEL;
				nxt_s.r.latch = scc_pkg::RST_LEVEL;
				nxt_s.cnt = '0;
				if (s_ff.r.nv_misc[scc_pkg::MISC_POST]) begin
					nxt_s.seq = scc_pkg::SCC_POST_OFF;
					nxt_s.busy = 1'b1;
				end else begin
					nxt_s.seq = scc_pkg::SCC_IDLE;
					nxt_s.busy = 1'b0;
				end
			end
			scc_pkg::SCC_POST_OFF: begin
				nxt_s.cnt = s_ff.cnt + 24'h000001;
				if (s_ff.cnt == 24'(SETTLE_CYCLES - 1)) begin
					nxt_s.x0 = sensor_out[scc_pkg::SENS_X_ACCEL];
					nxt_s.y0 = sensor_out[scc_pkg::SENS_Y_ACCEL];
					nxt_s.post_force = 1'b1;
					nxt_s.cnt = '0;
					nxt_s.seq = scc_pkg::SCC_POST_ON;
				end
			end
			scc_pkg::SCC_POST_ON: begin
				nxt_s.cnt = s_ff.cnt + 24'h000001;
				if (s_ff.cnt == 24'(SETTLE_CYCLES - 1)) begin
					dx = {sensor_out[scc_pkg::SENS_X_ACCEL][13], sensor_out[scc_pkg::SENS_X_ACCEL]}
						- {s_ff.x0[13], s_ff.x0};
					dy = {sensor_out[scc_pkg::SENS_Y_ACCEL][13], sensor_out[scc_pkg::SENS_Y_ACCEL]}
						- {s_ff.y0[13], s_ff.y0};
					ax = dx[14] ? 15'(-dx) : dx;
					ay = dy[14] ? 15'(-dy) : dy;
					st_fail_ev = (ax < 15'(ST_LIMIT)) || (ay < 15'(ST_LIMIT));
					nxt_s.post_force = 1'b0;
					nxt_s.cnt = '0;
					nxt_s.busy = 1'b0;
					nxt_s.seq = scc_pkg::SCC_IDLE;
				end
			end
			scc_pkg::SCC_BACKUP: begin
				nxt_s.cnt = s_ff.cnt + 24'h000001;
				if (s_ff.cnt == 24'(BACKUP_CYCLES - 1)) begin
					if (flash_ok) begin
						nxt_s.r.nv_misc = s_ff.r.misc;
						nxt_s.r.nv_dir = s_ff.r.dir;
						nxt_s.r.nv_dat = s_ff.r.dat;
						nxt_s.r.nv_offs = s_ff.r.offs;
					end else begin
						fl_fail_ev = 1'b1;
					end
					nxt_s.cnt = '0;
					nxt_s.busy = 1'b0;
					nxt_s.seq = scc_pkg::SCC_IDLE;
				end
			end
			default: begin
				nxt_s.seq = scc_pkg::SCC_IDLE;
				nxt_s.busy = 1'b0;
			end
		endcase

		// Hardware set beats a clear in the same cycle
		if (st_fail_ev) begin
			nxt_s.r.st_fail = 1'b1;
		end
		if (fl_fail_ev) begin
			nxt_s.r.fl_err = 1'b1;
		end

		// ------------------------------------
		// Force output
		// ------------------------------------
		nxt_s.st_force = nxt_s.r.misc[scc_pkg::MISC_ST_FORCE] | nxt_s.post_force;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff.seq <= scc_pkg::SCC_RELOAD;
			s_ff.cnt <= '0;
			s_ff.r.misc <= scc_pkg::RST_MISC;
			s_ff.r.dir <= scc_pkg::RST_LINE;
			s_ff.r.dat <= scc_pkg::RST_LINE;
			s_ff.r.level <= scc_pkg::RST_LEVEL;
			s_ff.r.latch <= scc_pkg::RST_LEVEL;
			s_ff.r.offs <= '0;
			s_ff.r.nv_misc <= NV_MISC_INIT;
			s_ff.r.nv_dir <= scc_pkg::RST_LINE;
			s_ff.r.nv_dat <= scc_pkg::RST_LINE;
			s_ff.r.nv_offs <= '0;
			s_ff.r.st_fail <= 1'b0;
			s_ff.r.fl_err <= 1'b0;
			s_ff.r.null_pend <= 1'b0;
			s_ff.x0 <= scc_pkg::RST_OFFSET;
			s_ff.y0 <= scc_pkg::RST_OFFSET;
			s_ff.post_force <= 1'b0;
			s_ff.st_force <= 1'b0;
			s_ff.busy <= 1'b1;
			s_ff.restart <= 1'b0;
			s_ff.tx <= 16'h0000;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from state
	// ----------------------------------------
	assign st_force = s_ff.st_force;
	assign level_latch = s_ff.r.latch;
	assign offsets = s_ff.r.offs;
	assign busy = s_ff.busy;
	assign core_restart = s_ff.restart;
	// Data reaches a pin only under its output direction
	assign line_out = s_ff.r.dat & s_ff.r.dir;
	assign line_oe = s_ff.r.dir;

endmodule : scc_regs

`default_nettype wire

// ==== dv/scc_regs_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module scc_regs_props #(
	parameter int BACKUP_CYCLES = 20,
	parameter int SETTLE_CYCLES = 10
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial and lines
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic [1:0] line_in,
	input wire logic [1:0] line_out,
	input wire logic [1:0] line_oe,
	// Sensor side and sequencer
	input wire logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] sensor_out,
	input wire logic flash_ok,
	input wire logic st_force,
	input wire logic [scc_pkg::LEVEL_W-1:0] level_latch,
	input wire logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] offsets,
	input wire logic busy,
	input wire logic core_restart
);
	// Power-on test plus one backup, with slack
	localparam int BUSY_MAX = BACKUP_CYCLES + 2 * SETTLE_CYCLES + 8;
	logic sclk_ff, done_ff, nxt_done, go;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] sh_ff, nxt_sh;
	logic [3:0] since_ff, nxt_since;
	logic [23:0] run_ff, nxt_run;
	logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] neg;
	// ----------------------------------------
	// Frame mirror
	// ----------------------------------------
	always_comb begin
		nxt_cnt = cs_n ? 5'h00 : cnt_ff;
		nxt_sh = sh_ff;
		nxt_done = 1'b0;
		if (!cs_n && sclk && !sclk_ff) begin
			nxt_sh = {sh_ff[14:0], mosi};
			nxt_cnt = cnt_ff + 5'h01;
			nxt_done = (cnt_ff == 5'h0F);
		end
		nxt_since = (since_ff == 4'hF) ? since_ff : since_ff + 4'h1;
		if (go && (sh_ff == 16'hBE04 || sh_ff == 16'hBE80)) begin
			nxt_since = 4'h0;
		end
		nxt_run = busy ? run_ff + 24'h000001 : 24'h000000;
		for (int i = 0; i < scc_pkg::N_OUT; i++) begin
			neg[i] = -sensor_out[i];
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_ff <= 1'b1;
			done_ff <= 1'b0;
			cnt_ff <= 5'h00;
			sh_ff <= 16'h0000;
			since_ff <= 4'hF;
			run_ff <= 24'h000000;
		end else begin
			sclk_ff <= sclk;
			done_ff <= nxt_done;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			since_ff <= nxt_since;
			run_ff <= nxt_run;
		end
	end
	assign go = done_ff && !busy;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_line_gate: assert property ((line_out & ~line_oe) == 2'h0)
		else $error("line driven while input");
	a_line_dir: assert property (go && sh_ff[15:8] == 8'hB6 |-> ##[1:4] line_oe == sh_ff[1:0])
		else $error("direction not applied");
	a_force_ctrl: assert property (go && sh_ff[15:1] == 15'h5A80 |-> ##[1:4] st_force == sh_ff[0])
		else $error("force not following control");
	a_restart_cmd: assert property (go && sh_ff == 16'hBE80 |-> ##[1:4] core_restart)
		else $error("no restart pulse");
	a_restart_once: assert property (core_restart |=> !core_restart)
		else $error("restart pulse too long");
	a_restore_zero: assert property (go && sh_ff == 16'hBE02 |-> ##[1:4] offsets == '0)
		else $error("offsets not restored");
	a_null_neg: assert property (go && sh_ff == 16'hBE01 |-> ##[1:4] offsets == neg)
		else $error("offsets not negated outputs");
	a_latch_cause: assert property ($changed(level_latch) |-> since_ff < 4'h8)
		else $error("latch moved without command");
	a_busy_bound: assert property (run_ff <= 24'(BUSY_MAX))
		else $error("busy too long");
endmodule : scc_regs_props
`default_nettype wire

// ==== dv/scc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module scc_host (
	// Clock
	input wire logic ref_clk,
	// Serial pins
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// Mode 3 frame, MSB first; returns the reply to the previous read
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge ref_clk);
			sclk <= 1'b0;
			mosi <= w[i];
			repeat (3) @(posedge ref_clk);
			sclk <= 1'b1;
			@(posedge ref_clk);
			r[i] = miso;
		end
		@(posedge ref_clk);
		cs_n <= 1'b1;
		mosi <= ~w[0];
		repeat (4) @(posedge ref_clk);
	endtask : xfer
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		xfer({1'b1, a, d}, r);
	endtask : wr
	// Second frame asks for an unmapped place
	task automatic rd(input logic [6:0] a, output logic [15:0] r);
		xfer({1'b0, a, 8'h00}, r);
		xfer(16'h0000, r);
	endtask : rd
endmodule : scc_host
`default_nettype wire

// ==== dv/scc_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module scc_regs_test;
	localparam int BK = 20;
	localparam int ST = 10;
	logic ref_clk, rst_n, sclk, cs_n, mosi, miso, flash_ok, st_force, busy, core_restart;
	logic [1:0] line_ext, line_in, line_out, line_oe, dr, dt, lv;
	logic [scc_pkg::N_OUT-1:0][scc_pkg::OFF_W-1:0] sensor_out, offsets, base;
	logic [scc_pkg::LEVEL_W-1:0] level_latch;
	logic [15:0] r;
	logic [31:0] seed;
	int miscompares, samples_checked, dlt, c, m_latch;
	int m_off[$];
	logic [6:0] zr [4] = '{7'h30, 7'h36, 7'h3E, 7'h00};
	// Wire level seen by the pins
	assign line_in = (line_oe & line_out) | (~line_oe & line_ext);
	scc_host host_inst (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	scc_regs #(.BACKUP_CYCLES(BK), .SETTLE_CYCLES(ST), .NV_MISC_INIT(16'h0400)) scc_regs_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.line_in(line_in), .line_out(line_out), .line_oe(line_oe), .sensor_out(sensor_out),
		.flash_ok(flash_ok), .st_force(st_force), .level_latch(level_latch), .offsets(offsets),
		.busy(busy), .core_restart(core_restart));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	task automatic wait_idle();
		c = 0;
		while (busy !== 1'b0) begin
			@(posedge ref_clk);
			c++;
			if (c > 5000) begin
				miscompares++;
				$display("MISMATCH busy exp 0 got 1");
				final_report();
			end
		end
	endtask : wait_idle
	task automatic rchk(input logic [6:0] a, input logic [15:0] e);
		host_inst.rd(a, r);
		chk($sformatf("reg %h", a), e, r);
	endtask : rchk
	task automatic cmd(input logic [7:0] v);
		host_inst.wr(7'h3E, v);
		wait_idle();
	endtask : cmd
	task automatic offs_chk();
		for (int i = 0; i < scc_pkg::N_OUT; i++) begin
			chk("offset", {2'h0, 14'(m_off[i])}, {2'h0, offsets[i]});
		end
	endtask : offs_chk
	// Sensor echo: self-test force shifts both accel axes
	always @(posedge ref_clk) begin
		sensor_out[4:2] <= base[4:2];
		sensor_out[0] <= base[0] + (st_force ? 14'(dlt) : 14'h0000);
		sensor_out[1] <= base[1] + (st_force ? 14'(dlt) : 14'h0000);
	end
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		rst_n = 1'b0;
		flash_ok = 1'b1;
		line_ext = 2'h0;
		base = '0;
		dlt = 100;
		seed = 32'h27F7;
		miscompares = 0;
		samples_checked = 0;
		m_latch = 0;
		repeat (10) @(posedge ref_clk);
		chk("busy in reset", 16'h0001, {15'h0000, busy});
		rst_n <= 1'b1;
		@(posedge ref_clk);
		wait_idle();
		rchk(7'h3C, (dlt < scc_pkg::ST_LIMIT_LSB) ? 16'h0020 : 16'h0000);
		foreach (zr[i]) rchk(zr[i], 16'h0000);
		$display("test power_on done");
		cmd(8'h10);
		rchk(7'h3C, 16'h0000);
		dlt = 400;
		host_inst.wr(7'h35, 8'h01);
		chk("force", 16'h0001, {15'h0000, st_force});
		chk("st delta", 16'h0001, {15'h0000, int'(sensor_out[0]) - int'(base[0]) >= scc_pkg::ST_LIMIT_LSB});
		host_inst.wr(7'h35, 8'h00);
		chk("force", 16'h0000, {15'h0000, st_force});
		$display("test self_test done");
		for (int d = 0; d < 4; d++) begin
			seed = lfsr(seed);
			dr = 2'(d);
			dt = seed[3:2];
			line_ext <= seed[1:0];
			host_inst.wr(7'h37, {6'h00, dt});
			host_inst.wr(7'h36, {6'h00, dr});
			lv = (dr & dt) | (~dr & line_ext);
			rchk(7'h36, {6'h00, lv, 6'h00, dr});
			chk("line oe", {14'h0000, dr}, {14'h0000, line_oe});
			chk("line out", {14'h0000, dr & dt}, {14'h0000, line_out});
		end
		$display("test lines done");
		seed = lfsr(seed);
		host_inst.wr(7'h30, seed[7:0]);
		host_inst.wr(7'h31, {4'h0, seed[11:8]});
		chk("latch held", 16'(m_latch), {4'h0, level_latch});
		rchk(7'h30, {4'h0, seed[11:0]});
		cmd(8'h04);
		m_latch = int'(seed[11:0]);
		chk("latch", 16'(m_latch), {4'h0, level_latch});
		$display("test level done");
		flash_ok <= 1'b0;
		host_inst.wr(7'h3E, 8'h08);
		chk("busy", 16'h0001, {15'h0000, busy});
		wait_idle();
		chk("backup time", 16'h0001, {15'h0000, c >= BK - 8 && c <= BK});
		rchk(7'h3C, 16'h0004);
		rchk(7'h3C, 16'h0000);
		flash_ok <= 1'b1;
		cmd(8'h08);
		rchk(7'h3C, 16'h0000);
		$display("test backup done");
		for (int i = 0; i < scc_pkg::N_OUT; i++) begin
			seed = lfsr(seed);
			base[i] <= seed[13:0];
			m_off.push_back(int'(-seed[13:0]));
		end
		repeat (2) @(posedge ref_clk);
		cmd(8'h01);
		offs_chk();
		cmd(8'h02);
		foreach (m_off[i]) chk("restore", 16'h0000, {2'h0, offsets[i]});
		$display("test offsets done");
		cmd(8'h80);
		offs_chk();
		chk("latch reset", 16'h0000, {4'h0, level_latch});
		rchk(7'h30, 16'h0000);
		$display("test soft_reset done");
		final_report();
	end
endmodule : scc_regs_test
bind scc_regs scc_regs_props #(.BACKUP_CYCLES(BACKUP_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) props_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
	.line_in(line_in), .line_out(line_out), .line_oe(line_oe), .sensor_out(sensor_out),
	.flash_ok(flash_ok), .st_force(st_force), .level_latch(level_latch), .offsets(offsets),
	.busy(busy), .core_restart(core_restart));
`default_nettype wire
